// ===== lbalu_core.sv
// execution datapath for add, and, bit set/clear and bit-test-skip
`timescale 1ns/1ps
// What this block does
// - add immediate: accumulator plus literal to accumulator, all flags
// - add register: accumulator plus file register, all flags
// - destination bit 0 writes accumulator, 1 the addressed file register
// - and immediate: accumulator and literal to accumulator, zero flag only
// - and register: accumulator and file register to destination, zero only
// - bit clear forces indexed bit of file register to zero, no flags
// - bit set forces indexed bit of file register to one, no flags
// - skip if one discards next instruction as a nop when bit is one
// - skip if zero discards next instruction as a nop when bit is zero
module lbalu_core
	import lbalu_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire logic                op_valid,
	input  wire lbalu_req_t          op_req,
	output logic [DATA_W-1:0]        acc_q,
	output logic                     carry_q,
	output logic                     nibble_ovf_flag_q,
	output logic                     zero_q,
	output lbalu_wr_t                file_wr_q,
	output logic                     squash_q,
	output logic                     op_done_q
);

	// ****************************************************************
	// state
	// ****************************************************************
	lbalu_state_t          s_q;
	lbalu_state_t          s_d;
	logic                  take;
	logic [DATA_W:0]       sum_w;
	logic [NIB_MSB+1:0]    sum_nib;
	logic [DATA_W-1:0]     add_src;
	logic [DATA_W-1:0]     and_src;
	logic [DATA_W-1:0]     add_res;
	logic [DATA_W-1:0]     and_res;
	logic [DATA_W-1:0]     bit_mask;
	logic                  tested_bit;

	function automatic logic [DATA_W-1:0] onehot_bit(
		input logic [BIT_W-1:0] idx);
		logic [DATA_W-1:0] m;
		m = '0;
		m[idx] = 1'b1;
		return m;
	endfunction

	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return (v == '0);
	endfunction

	// ****************************************************************
	// datapath
	// ****************************************************************
	always_comb begin
		take       = op_valid && (s_q.st == ST_RUN);
		add_src    = (op_req.op == add_immediate_op) ? op_req.literal
			: op_req.file_data;
		and_src    = (op_req.op == and_immediate_op) ? op_req.literal
			: op_req.file_data;
		sum_w      = {1'b0, s_q.w} + {1'b0, add_src};
		sum_nib    = {1'b0, s_q.w[NIB_MSB:0]}
			+ {1'b0, add_src[NIB_MSB:0]};
		add_res    = sum_w[DATA_W-1:0];
		and_res    = s_q.w & and_src;
		bit_mask   = onehot_bit(op_req.bit_idx);
		tested_bit = |(op_req.file_data & bit_mask);
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s_d          = s_q;
		s_d.wr.wr_en = 1'b0;
		s_d.squash   = 1'b0;
		s_d.done     = 1'b0;
		case (s_q.st)
			ST_RUN: begin
				if (take) begin
					s_d.done       = 1'b1;
					s_d.wr.wr_addr = op_req.addr;
					case (op_req.op)
						add_immediate_op: begin
							s_d.w               = add_res;
							s_d.carry           = sum_w[DATA_W];
							s_d.nibble_ovf_flag = sum_nib[NIB_MSB+1];
							s_d.zero            = is_zero(add_res);
						end
						add_register_op: begin
							s_d.carry           = sum_w[DATA_W];
							s_d.nibble_ovf_flag = sum_nib[NIB_MSB+1];
							s_d.zero            = is_zero(add_res);
							if (op_req.dest == DEST_FILE) begin
								s_d.wr.wr_en   = 1'b1;
								s_d.wr.wr_data = add_res;
							end else begin
								s_d.w = add_res;
							end
						end
						and_immediate_op: begin
							s_d.w    = and_res;
							s_d.zero = is_zero(and_res);
						end
						and_register_op: begin
							s_d.zero = is_zero(and_res);
							if (op_req.dest == DEST_FILE) begin
								s_d.wr.wr_en   = 1'b1;
								s_d.wr.wr_data = and_res;
							end else begin
								s_d.w = and_res;
							end
						end
						bit_clear_op: begin
							s_d.wr.wr_en   = 1'b1;
							s_d.wr.wr_data = op_req.file_data & ~bit_mask;
						end
						bit_set_op: begin
							s_d.wr.wr_en   = 1'b1;
							s_d.wr.wr_data = op_req.file_data | bit_mask;
						end
						skip_if_one_op: begin
							if (tested_bit) begin
								s_d.st = ST_SKIP;
							end
						end
						skip_if_zero_op: begin
							if (!tested_bit) begin
								s_d.st = ST_SKIP;
							end
						end
						default: begin
							s_d.done = 1'b0;
						end
					endcase
				end
			end
			ST_SKIP: begin
				// second cycle of a taken skip runs as a nop
				s_d.squash = 1'b1;
				s_d.st     = ST_RUN;
			end
			default: begin
				s_d.st = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q.st              <= ST_RUN;
			s_q.w               <= W_RST;
			s_q.carry           <= FLAG_RST;
			s_q.nibble_ovf_flag <= FLAG_RST;
			s_q.zero            <= FLAG_RST;
			s_q.wr              <= '0;
			s_q.squash          <= 1'b0;
			s_q.done            <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	always_comb begin
		acc_q             = s_q.w;
		carry_q           = s_q.carry;
		nibble_ovf_flag_q = s_q.nibble_ovf_flag;
		zero_q            = s_q.zero;
		file_wr_q         = s_q.wr;
		squash_q          = s_q.squash;
		op_done_q         = s_q.done;
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence take_op(lbalu_op_t o);
		take && (op_req.op == o);
	endsequence

	sequence skip_taken;
		take && ((op_req.op == skip_if_one_op && tested_bit)
			|| (op_req.op == skip_if_zero_op && !tested_bit));
	endsequence

	AST_ADD_IMM: assert property (take_op(add_immediate_op) |=>
		acc_q == $past(add_res) && carry_q == $past(sum_w[DATA_W])
		&& nibble_ovf_flag_q == $past(sum_nib[NIB_MSB+1]))
		else $error("add immediate result or flags wrong");

	AST_ADD_REG: assert property (take_op(add_register_op)
		##0 (op_req.dest == DEST_FILE) |=> file_wr_q.wr_en
		&& file_wr_q.wr_data == $past(add_res)
		&& $stable(acc_q) && carry_q == $past(sum_w[DATA_W]))
		else $error("add register to file wrong");

	AST_DEST_ACC: assert property ((take_op(add_register_op)
		or take_op(and_register_op)) ##0 (op_req.dest == DEST_ACC)
		|=> !file_wr_q.wr_en)
		else $error("destination accumulator wrote the file");

	AST_AND_IMM: assert property (take_op(and_immediate_op) |=>
		acc_q == $past(and_res) && $stable(carry_q)
		&& $stable(nibble_ovf_flag_q))
		else $error("and immediate touched wrong state");

	AST_AND_REG: assert property (take_op(and_register_op)
		##0 (op_req.dest == DEST_ACC) |=> acc_q == $past(and_res)
		&& $stable(carry_q))
		else $error("and register to accumulator wrong");

	AST_BIT_CLR: assert property (take_op(bit_clear_op) |=>
		file_wr_q.wr_en && !(file_wr_q.wr_data[$past(op_req.bit_idx)])
		&& $stable(zero_q) && $stable(carry_q))
		else $error("bit clear wrong");

	AST_BIT_SET: assert property (take_op(bit_set_op) |=>
		file_wr_q.wr_en && file_wr_q.wr_data[$past(op_req.bit_idx)]
		&& $stable(zero_q) && $stable(nibble_ovf_flag_q))
		else $error("bit set wrong");

	AST_SKIP: assert property (skip_taken |=> !squash_q
		##1 squash_q && !file_wr_q.wr_en && $stable(acc_q) ##1 !squash_q)
		else $error("taken skip did not squash exactly one slot");

	AST_NO_SKIP: assert property ((take_op(skip_if_one_op)
		##0 !tested_bit) or (take_op(skip_if_zero_op) ##0 tested_bit)
		|=> ##1 !squash_q)
		else $error("untaken skip squashed");

	AST_ZERO: assert property ((take_op(add_immediate_op)
		or take_op(and_immediate_op)) |=> zero_q == (acc_q == '0))
		else $error("zero flag mismatch");

endmodule

// ===== lbalu_pkg.sv
// shared types and constants of the literal and bit alu datapath
package lbalu_pkg;

	// ****************************************************************
	// widths and reset values
	// ****************************************************************
	localparam int         DATA_W      = 8;
	localparam int         ADDR_W      = 7;
	localparam int         BIT_W       = 3;
	localparam int         NIB_MSB     = 3;
	localparam logic [7:0] W_RST       = 8'h00;
	localparam logic       FLAG_RST    = 1'b0;
	localparam logic       DEST_ACC    = 1'b0;
	localparam logic       DEST_FILE   = 1'b1;
	localparam int         TCY_NS      = 50;
	localparam int         SKIP_TCY    = 2;
	localparam int         SKIP_CYC    = SKIP_TCY * TCY_NS / TCY_NS;

	// ****************************************************************
	// operation codes, one-hot
	// ****************************************************************
	typedef enum logic [7:0] {
		add_immediate_op = 8'h01,
		add_register_op  = 8'h02,
		and_immediate_op = 8'h04,
		and_register_op  = 8'h08,
		bit_clear_op     = 8'h10,
		bit_set_op       = 8'h20,
		skip_if_one_op   = 8'h40,
		skip_if_zero_op  = 8'h80
	} lbalu_op_t;

	typedef enum logic [1:0] {
		ST_RUN  = 2'h1,
		ST_SKIP = 2'h2
	} lbalu_st_t;

	// instruction as handed over by decode, file operand already read
	typedef struct packed {
		lbalu_op_t           op;
		logic                dest;
		logic [ADDR_W-1:0]   addr;
		logic [BIT_W-1:0]    bit_idx;
		logic [DATA_W-1:0]   literal;
		logic [DATA_W-1:0]   file_data;
	} lbalu_req_t;

	typedef struct packed {
		logic                wr_en;
		logic [ADDR_W-1:0]   wr_addr;
		logic [DATA_W-1:0]   wr_data;
	} lbalu_wr_t;

	typedef struct packed {
		lbalu_st_t           st;
		logic [DATA_W-1:0]   w;
		logic                carry;
		logic                nibble_ovf_flag;
		logic                zero;
		lbalu_wr_t           wr;
		logic                squash;
		logic                done;
	} lbalu_state_t;

endpackage

// ===== lbalu_fmem.sv
// partner model: file register space behind the datapath
`timescale 1ns/1ps
module lbalu_fmem
	import lbalu_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire lbalu_wr_t         file_wr_q,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0]      rd_data
);
	logic [DATA_W-1:0] mem [128];
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
	// bypass so a write just made is seen at once
	assign rd_data = (file_wr_q.wr_en && file_wr_q.wr_addr == rd_addr) ?
		file_wr_q.wr_data : mem[rd_addr];
	always @(posedge clk_sys) begin
		if (file_wr_q.wr_en)
			mem[file_wr_q.wr_addr] <= file_wr_q.wr_data;
	end
endmodule

// ===== tb_top.sv
// self-checking bench of the literal and bit alu datapath
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
	import lbalu_pkg::*;
	logic              clk_sys = 1'b0;
	logic              rst_n = 1'b0;
	logic              op_valid = 1'b0;
	lbalu_req_t        req_b = '0;
	lbalu_req_t        req_w;
	logic [7:0]        acc_q, fdat;
	logic              carry_q, nibble_ovf_flag_q, zero_q;
	logic              squash_q, op_done_q;
	lbalu_wr_t         file_wr_q;
	logic [31:0]       seed = 32'h1544;
	int                fail_count = 0, tests_run = 0, cyc = 0;
	logic [7:0]        e_mem [128];
	logic [7:0]        e_acc = 8'h00;
	logic              e_c = 0, e_nov = 0, e_z = 0, e_skp = 0;

	always #25 clk_sys = ~clk_sys;
	always_comb begin
		req_w = req_b;
		req_w.file_data = fdat;
	end
	lbalu_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
		.op_req(req_w), .acc_q(acc_q), .carry_q(carry_q),
		.nibble_ovf_flag_q(nibble_ovf_flag_q), .zero_q(zero_q),
		.file_wr_q(file_wr_q), .squash_q(squash_q), .op_done_q(op_done_q));
	lbalu_fmem fmem_u (.clk_sys(clk_sys), .file_wr_q(file_wr_q),
		.rd_addr(req_b.addr), .rd_data(fdat));

	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	// expected {nibble carry, carry, sum} of an 8-bit add
	function automatic logic [9:0] add_exp(logic [7:0] x, logic [7:0] y);
		logic [4:0] lo;
		lo = {1'b0, x[3:0]} + {1'b0, y[3:0]};
		return {lo[4], {1'b0, x} + {1'b0, y}};
	endfunction

	task automatic final_report();
		$display("checks %0d errors %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************************
	// one instruction slot: drive, predict, check
	// ****************************************************************
	task automatic step(lbalu_op_t op, logic d, logic [6:0] a,
		logic [2:0] b, logic [7:0] k);
		logic [7:0] f, f2, r;
		logic       we, dn, sq, nskp;
		op_valid = 1'b1;
		req_b = '{op, d, a, b, k, 8'h00};
		f = e_mem[a];
		r = e_acc;
		we = 0;
		nskp = 0;
		sq = e_skp;
		dn = !e_skp;
		if (!e_skp) case (op)
			add_immediate_op, add_register_op: begin
				f2 = (op == add_immediate_op) ? k : f;
				{e_nov, e_c, r} = add_exp(e_acc, f2);
			end
			and_immediate_op: r = e_acc & k;
			and_register_op: r = e_acc & f;
			bit_clear_op: begin r = f; r[b] = 1'b0; end
			bit_set_op: begin r = f; r[b] = 1'b1; end
			skip_if_one_op: nskp = f[b];
			skip_if_zero_op: nskp = !f[b];
			default: dn = 0;
		endcase
		if (dn && op[3:0] != 4'h0) begin
			e_z = (r == 8'h00);
			if ((op[1] | op[3]) && d)
				we = 1;
			else
				e_acc = r;
		end
		if (dn && op[5:4] != 2'h0)
			we = 1;
		if (we)
			e_mem[a] = r;
		@(negedge clk_sys);
		`CHK("acc", e_acc, acc_q)
		`CHK("carry", e_c, carry_q)
		`CHK("nibble_ovf", e_nov, nibble_ovf_flag_q)
		`CHK("zero", e_z, zero_q)
		`CHK("wr_en", we, file_wr_q.wr_en)
		if (we) `CHK("wr_addr", a, file_wr_q.wr_addr)
		if (we) `CHK("wr_data", r, file_wr_q.wr_data)
		`CHK("done", dn, op_done_q)
		`CHK("squash", sq, squash_q)
		e_skp = nskp;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			final_report();
		end
	end

	initial begin
		for (int i = 0; i < 128; i++) e_mem[i] = 8'(i * 37);
		repeat (3) @(negedge clk_sys);
		rst_n = 1'b1;
		step(add_immediate_op, 0, 0, 0, 8'h0F);
		step(add_immediate_op, 0, 0, 0, 8'h01);
		step(add_immediate_op, 0, 0, 0, 8'hF0);
		step(lbalu_op_t'(8'h03), 0, 0, 0, 8'hFF);
		step(skip_if_zero_op, 0, 7'h00, 3'h0, 8'h00);
		step(bit_set_op, 1, 7'h00, 3'h7, 8'h00);
		step(bit_set_op, 1, 7'h00, 3'h7, 8'h00);
		step(skip_if_one_op, 0, 7'h00, 3'h7, 8'h00);
		step(skip_if_one_op, 0, 7'h00, 3'h7, 8'h00);
		step(add_register_op, 1, 7'h05, 3'h0, 8'h00);
		step(and_register_op, 0, 7'h05, 3'h0, 8'h00);
		repeat (800) begin
			seed = xs(seed);
			step(lbalu_op_t'(8'h01 << seed[2:0]), seed[3],
				{3'h0, seed[7:4]}, seed[10:8], seed[18:11]);
		end
		final_report();
	end
endmodule
